// ---- logic/dac_latch_powerdown_control.sv ----
// Volatile DAC registers, wiper transfer under the hold pin, sleep selects.
// Assumes an AXI4-Lite master on aclk; hold pin from an unrelated source.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dac_latch_powerdown_control
    import dac_ctl_pkg::*;
#(
    parameter int NCH = 2,
    parameter int DAC_W = 12,
    parameter int ENTRY_CNT = ENTRY_CYCLES,
    parameter int EXIT_CNT = EXIT_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic transfer_hold_pin,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NCH*DAC_W-1:0] wiper_q,
    output out_ctl_s [NCH-1:0] out_ctl_q
);
    logic hold_meta_q;
    logic hold_sync_q;
    logic [DAC_W-1:0] dac_q [NCH];
    logic [1:0] sleep_sel_q [NCH];
    logic [31:0] shadow_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    logic do_write;
    logic gen_reset;
    logic gen_wake;
    logic [DATA_W-1:0] rdata_d;
    logic rd_ok;

    // Two-flop synchroniser; the pin is unrelated to the bus clock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_meta_q <= 1'b0;
            hold_sync_q <= 1'b0;
        end
        else if (ce)
        begin
            hold_meta_q <= transfer_hold_pin;
            hold_sync_q <= hold_meta_q;
        end
    end

    // Address and data may arrive in either order; commit once both held
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    OFS_DAC0, OFS_DAC1, OFS_SLEEP, OFS_SHADOW, OFS_CMD:
                        s_axi_bresp <= RESP_OKAY;
                    default:
                        s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Command strobes are self-clearing
    assign gen_reset = do_write && (awaddr_q == OFS_CMD) && wstrb_q[0]
        && wdata_q[CMD_RESET_BIT];
    assign gen_wake = do_write && (awaddr_q == OFS_CMD) && wstrb_q[0]
        && wdata_q[CMD_WAKE_BIT];

    // Shadow stands for the nonvolatile copy; low byte holds DAC0 reload, next byte DAC1
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            shadow_q <= SHADOW_RST;
        else if (ce && do_write && awaddr_q == OFS_SHADOW)
        begin
            for (int b = 0; b < 4; b++)
                if (wstrb_q[b])
                    shadow_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            localparam logic [ADDR_W-1:0] DAC_OFS = (ch % 2 == 1) ? OFS_DAC1 : OFS_DAC0;

            // Volatile value lands when the write completes, blocked or not
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    dac_q[ch] <= '0;
                else if (ce)
                begin
                    if (gen_reset)
                        dac_q[ch] <= DAC_W'(shadow_q[(ch % 2) * 8 +: 8]);
                    else if (do_write && awaddr_q == DAC_OFS && wstrb_q[0])
                        dac_q[ch] <= wdata_q[DAC_W-1:0];
                end
            end

            // Level-sensitive copy; a held pin keeps the old wiper through wake
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    wiper_q[ch*DAC_W +: DAC_W] <= '0;
                else if (ce && !hold_sync_q)
                    wiper_q[ch*DAC_W +: DAC_W] <= dac_q[ch];
            end

            // Only a register write, a wake-up, a general reset or the power-on load moves the select
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    sleep_sel_q[ch] <= SHADOW_RST[SHD_SLEEP_LSB + 2*ch +: 2];
                else if (ce)
                begin
                    if (gen_reset)
                        sleep_sel_q[ch] <= SEL_RUN;
                    else if (gen_wake)
                        sleep_sel_q[ch] <= SEL_RUN;
                    else if (do_write && awaddr_q == OFS_SLEEP && wstrb_q[0])
                        sleep_sel_q[ch] <= wdata_q[2*ch +: 2];
                end
            end

            sleep_channel #(
                .ENTRY_CNT(ENTRY_CNT),
                .EXIT_CNT(EXIT_CNT)
            ) u_sleep (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .sel(sleep_sel_q[ch]),
                .ctl_q(out_ctl_q[ch])
            );
        end
    endgenerate

    always_comb
    begin
        rdata_d = '0;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFS_DAC0: rdata_d[DAC_W-1:0] = dac_q[0];
            OFS_DAC1: rdata_d[DAC_W-1:0] = dac_q[NCH-1];
            OFS_SLEEP:
                for (int i = 0; i < NCH; i++)
                    rdata_d[2*i +: 2] = sleep_sel_q[i];
            OFS_SHADOW: rdata_d = shadow_q;
            OFS_CMD: rdata_d = '0;
            OFS_WIPER0: rdata_d[DAC_W-1:0] = wiper_q[0 +: DAC_W];
            OFS_WIPER1: rdata_d[DAC_W-1:0] = wiper_q[(NCH-1)*DAC_W +: DAC_W];
            OFS_STATUS:
            begin
                rdata_d[0] = hold_sync_q;
                for (int i = 0; i < NCH; i++)
                    rdata_d[1+i] = out_ctl_q[i].drive_en;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // Read port serves commands in every sleep state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- inc/dac_ctl_pkg.sv ----
// Constants and carrier types for the DAC latch and sleep control block.
// Assumes a 100 MHz aclk and an AXI4-Lite register bus with 32-bit data.
// Notes on behaviour
// - Hold pin high blocks all wiper copies
// - Hold pin low copies registers, level-sensitive
// - Held low, wiper follows each new write
// - Pin asynchronous; writes accepted while blocked
// - Each channel has its own sleep select
// - Select 00 run, 01 low R, 10 high R, 11 open
// - Sleep disables drive, keeps register values
// - Entry to sleep waits entry delay
// - Sleep bits change by write, wake-up, reset or power-on load
// - General reset reloads volatile from shadow
// - Command interface stays alive in sleep
// - Write 00, wake-up or reset clears sleep
// - Leaving sleep drives from current values
// - Blocked write stays unseen after wake
// - Exit from sleep waits exit delay
// - Volatile write lands at command end
package dac_ctl_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_DAC0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DAC1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SLEEP = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SHADOW = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_WIPER0 = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WIPER1 = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
    // Command register bits
    localparam int CMD_RESET_BIT = 0;
    localparam int CMD_WAKE_BIT = 1;
    // Shadow register layout
    localparam int SHD_SLEEP_LSB = 16;
    localparam logic [31:0] SHADOW_RST = 32'h0000_0000;
    localparam logic [1:0] SEL_RUN = 2'h0;
    localparam logic [1:0] SEL_LOW_R = 2'h1;
    localparam logic [1:0] SEL_HIGH_R = 2'h2;
    localparam logic [1:0] SEL_OPEN = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEEP_ENTRY_DELAY_NS = 10000;
    localparam int SLEEP_EXIT_DELAY_NS = 10000;
    localparam int ENTRY_CYCLES = SLEEP_ENTRY_DELAY_NS / CLK_PERIOD_NS;
    localparam int EXIT_CYCLES = (SLEEP_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef struct packed {
        logic drive_en;
        logic pull_low_r;
        logic pull_high_r;
        logic core_on;
    } out_ctl_s;
endpackage

// ---- logic/sleep_channel.sv ----
// One channel's sleep sequencer: entry and exit delays and output controls.
// Assumes sel arrives from a register in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module sleep_channel
    import dac_ctl_pkg::*;
#(
    parameter int ENTRY_CNT = ENTRY_CYCLES,
    parameter int EXIT_CNT = EXIT_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [1:0] sel,
    output out_ctl_s ctl_q
);
    typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_SLEEP, ST_EXIT} state_e;
    localparam int CW = $clog2((ENTRY_CNT > EXIT_CNT ? ENTRY_CNT : EXIT_CNT) + 1);
    state_e state_q;
    logic [CW-1:0] cnt_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_RUN;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            case (state_q)
                ST_RUN:
                    if (sel != SEL_RUN)
                    begin
                        state_q <= ST_ENTER;
                        cnt_q <= CW'(ENTRY_CNT - 1);
                    end
                ST_ENTER:
                    if (sel == SEL_RUN)
                        state_q <= ST_RUN;
                    else if (cnt_q == '0)
                        state_q <= ST_SLEEP;
                    else
                        cnt_q <= cnt_q - 1'b1;
                ST_SLEEP:
                    if (sel == SEL_RUN)
                    begin
                        state_q <= ST_EXIT;
                        cnt_q <= CW'(EXIT_CNT - 1);
                    end
                ST_EXIT:
                    if (sel != SEL_RUN)
                        state_q <= ST_SLEEP;
                    else if (cnt_q == '0)
                        state_q <= ST_RUN;
                    else
                        cnt_q <= cnt_q - 1'b1;
                default:
                    state_q <= ST_RUN;
            endcase
        end
    end

    // Output controls registered; core powers up at once on exit, drive waits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctl_q <= '{drive_en: 1'b1, pull_low_r: 1'b0, pull_high_r: 1'b0, core_on: 1'b1};
        else if (ce)
        begin
            ctl_q.drive_en <= (state_q == ST_RUN) || (state_q == ST_ENTER);
            ctl_q.core_on <= (state_q != ST_SLEEP);
            ctl_q.pull_low_r <= (state_q == ST_SLEEP) && (sel == SEL_LOW_R);
            ctl_q.pull_high_r <= (state_q == ST_SLEEP) && (sel == SEL_HIGH_R);
        end
    end
endmodule
`default_nettype wire

// ---- dv/hold_src.sv ----
// Stand-in for the external source of the hold pin.
// Free-runs on its own 7.3 ns timer, unrelated to aclk.
`timescale 1ns/1ps
`default_nettype none
module hold_src (
    input wire logic [1:0] mode,
    output logic pin
);
    initial pin = 1'b0;
    // Mode 0 ties the pin low, 1 holds it high, else it toggles freely
    always
    begin
        #7.3;
        case (mode)
            2'h0: pin = 1'b0;
            2'h1: pin = 1'b1;
            default: pin = ~pin;
        endcase
    end
endmodule
`default_nettype wire

// ---- dv/dac_ctl_checker.sv ----
// Assertions on the ports of the DAC latch and sleep control block.
// Assumes ce drops only while idle, and one write at a time on the bus.
`timescale 1ns/1ps
`default_nettype none
module dac_ctl_checker
    import dac_ctl_pkg::*;
#(
    parameter int NCH = 2,
    parameter int DAC_W = 12,
    parameter int ENTRY_CNT = 4,
    parameter int EXIT_CNT = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic transfer_hold_pin,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [NCH*DAC_W-1:0] wiper_q,
    input wire out_ctl_s [NCH-1:0] out_ctl_q
);
    localparam int ENT_LO = ENTRY_CNT - 1;
    localparam int SETTLE = ENTRY_CNT + EXIT_CNT + 8;
    logic [ADDR_W-1:0] aw_q;
    logic [DATA_W-1:0] wd_q;
    logic bv_q;
    logic commit;
    logic [2*NCH-1:0] sel_q;
    logic [2*NCH-1:0] sel_d;
    int lo_q;
    int sc_q;
    out_ctl_s [NCH-1:0] exp_ctl;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    assign commit = s_axi_bvalid && !bv_q && s_axi_bresp == RESP_OKAY;
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wd_q <= s_axi_wdata;
        bv_q <= s_axi_bvalid && aresetn;
        lo_q <= (transfer_hold_pin || !aresetn) ? 0 : (lo_q < 99 ? lo_q + 1 : lo_q);
    end
    // Lags the block by one cycle; only settled states are compared
    always_comb
    begin
        sel_d = sel_q;
        if (commit && aw_q == OFS_SLEEP)
            sel_d = wd_q[2*NCH-1:0];
        if (commit && aw_q == OFS_CMD && wd_q[1:0] != 2'h0)
            sel_d = '0;
        for (int c = 0; c < NCH; c++)
            exp_ctl[c] = (sel_q[2*c+:2] == SEL_RUN) ? 4'h9 :
                {1'b0, sel_q[2*c+:2] == SEL_LOW_R, sel_q[2*c+:2] == SEL_HIGH_R, 1'b0};
    end
    always_ff @(posedge aclk)
    begin
        sel_q <= aresetn ? sel_d : '0;
        sc_q <= (!aresetn || sel_d != sel_q) ? 0 : (sc_q < 999 ? sc_q + 1 : sc_q);
    end
    sequence s_entry;
        commit && aw_q == OFS_SLEEP && wd_q[1:0] != SEL_RUN && sel_q[1:0] == SEL_RUN
            && out_ctl_q[0].drive_en;
    endsequence
    sequence s_wake;
        commit && sel_q[1:0] != SEL_RUN && !out_ctl_q[0].drive_en
            && ((aw_q == OFS_SLEEP && wd_q[1:0] == SEL_RUN) || (aw_q == OFS_CMD && wd_q[1:0] != 2'h0));
    endsequence
    property p_hold;
        transfer_hold_pin[*3] |=> $stable(wiper_q);
    endproperty
    property p_follow;
        commit && lo_q > 3 && (aw_q == OFS_DAC0 || aw_q == OFS_DAC1)
            |-> ##[1:2] wiper_q[int'(aw_q[2])*DAC_W+:DAC_W] == wd_q[DAC_W-1:0];
    endproperty
    property p_settled;
        sc_q > SETTLE |-> out_ctl_q == exp_ctl;
    endproperty
    property p_no_fight;
        out_ctl_q[0].drive_en |-> !out_ctl_q[0].pull_low_r && !out_ctl_q[0].pull_high_r;
    endproperty
    property p_entry;
        s_entry |-> (out_ctl_q[0].drive_en throughout ##ENT_LO 1) ##[1:4] !out_ctl_q[0].drive_en;
    endproperty
    property p_exit;
        s_wake |-> (!out_ctl_q[0].drive_en throughout ##EXIT_CNT 1) ##[1:4] out_ctl_q[0].drive_en;
    endproperty
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_btime;
        s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid;
    endproperty
    property p_unmapped;
        s_axi_bvalid && !bv_q && aw_q > OFS_STATUS |-> s_axi_bresp == RESP_SLVERR;
    endproperty
    a_hold: assert property (p_hold) else $error("wiper moved while held");
    a_follow: assert property (p_follow) else $error("wiper missed write");
    a_settled: assert property (p_settled) else $error("output control wrong");
    a_no_fight: assert property (p_no_fight) else $error("pull with drive");
    a_entry: assert property (p_entry) else $error("entry delay wrong");
    a_exit: assert property (p_exit) else $error("exit delay wrong");
    a_bdone: assert property (p_bdone) else $error("write response stuck");
    a_btime: assert property (p_btime) else $error("write response late");
    a_unmapped: assert property (p_unmapped) else $error("unmapped write okay");
endmodule
`default_nettype wire

// ---- dv/tb_dac_latch_powerdown_control.sv ----
// Self-checking bench for the DAC latch and sleep control block.
// Assumes the hold pin source and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_dac_latch_powerdown_control;
    import dac_ctl_pkg::*;
    localparam int DLY = 4;
    localparam int WAIT = 2 * DLY + 12;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [1:0] hold_mode = 2'h0;
    logic hold_pin;
    logic [ADDR_W-1:0] s_axi_awaddr = '0;
    logic [ADDR_W-1:0] s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [DATA_W-1:0] s_axi_rdata;
    logic [23:0] wiper_q;
    out_ctl_s [1:0] out_ctl_q;
    int n_errors = 0;
    int checked = 0;
    always #5 aclk = ~aclk;
    hold_src u_src (.mode(hold_mode), .pin(hold_pin));
    dac_latch_powerdown_control #(.NCH(2), .DAC_W(12), .ENTRY_CNT(DLY), .EXIT_CNT(DLY)) DUT (
        .aclk, .aresetn, .ce, .transfer_hold_pin(hold_pin), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wiper_q, .out_ctl_q);
    task automatic end_sim();
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 200)
        begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        s_axi_bready <= 1'b0;
        guard(n);
        chk("bresp", 32'(s_axi_bresp), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        s_axi_rready <= 1'b0;
        guard(n);
        chk("rdata", s_axi_rdata, d);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask
    function automatic logic [3:0] exp_ctl(input logic [1:0] s);
        return s == SEL_RUN ? 4'h9 : {1'b0, s == SEL_LOW_R, s == SEL_HIGH_R, 1'b0};
    endfunction
    initial
    begin
        logic [31:0] d0, d1, sh;
        int s;
        s = $urandom(28);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(2);
        chk("ctl", 32'(out_ctl_q), 32'h99);
        rd(OFS_SLEEP, 0, RESP_OKAY);
        rd(8'h20 + 8'(4 * ($urandom % 8)), 0, RESP_SLVERR);
        wr(8'h40, 32'h5a, RESP_SLVERR);
        for (int i = 0; i < 6; i++)
        begin
            d0 = (i == 0) ? 32'hffff_ffff : $urandom;
            s = i % 2;
            wr(s ? OFS_DAC1 : OFS_DAC0, d0, RESP_OKAY);
            cyc(2);
            chk("wiper", 32'(wiper_q[s*12+:12]), 32'(d0[11:0]));
            rd(s ? OFS_DAC1 : OFS_DAC0, 32'(d0[11:0]), RESP_OKAY);
        end
        // Pin high: registers move, wipers and sleep exit must not expose them
        hold_mode <= 2'h1;
        cyc(5);
        sh = 32'(wiper_q);
        d0 = $urandom;
        d1 = $urandom;
        wr(OFS_DAC0, d0, RESP_OKAY);
        wr(OFS_DAC1, d1, RESP_OKAY);
        wr(OFS_SLEEP, 32'h5, RESP_OKAY);
        cyc(WAIT);
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_SLEEP, 0, RESP_OKAY);
        cyc(WAIT);
        chk("wiper", 32'(wiper_q), sh);
        rd(OFS_DAC0, 32'(d0[11:0]), RESP_OKAY);
        rd(OFS_WIPER0, 32'(sh[11:0]), RESP_OKAY);
        // Enable low: a released pin must not reach the wipers
        ce <= 1'b0;
        hold_mode <= 2'h0;
        cyc(10);
        chk("wiper", 32'(wiper_q), sh);
        ce <= 1'b1;
        hold_mode <= 2'h2;
        wr(OFS_DAC0, d1, RESP_OKAY);
        hold_mode <= 2'h0;
        cyc(5);
        chk("wiper", 32'(wiper_q), {8'h0, d1[11:0], d1[11:0]});
        sh = $urandom;
        wr(OFS_SHADOW, sh, RESP_OKAY);
        rd(OFS_SLEEP, 0, RESP_OKAY);
        for (int k = 1; k < 4; k++)
        begin
            d0 = 32'(k) | (32'(4 - k) << 2);
            wr(OFS_SLEEP, d0, RESP_OKAY);
            cyc(WAIT);
            chk("ctl", 32'(out_ctl_q), {exp_ctl(2'(4 - k)), exp_ctl(2'(k))});
            rd(OFS_SLEEP, d0, RESP_OKAY);
            wr(k == 1 ? OFS_SLEEP : OFS_CMD, 32'(k == 1 ? 0 : 4 - k), RESP_OKAY);
            cyc(WAIT);
            chk("ctl", 32'(out_ctl_q), 32'h99);
        end
        rd(OFS_DAC0, 32'(sh[7:0]), RESP_OKAY);
        rd(OFS_DAC1, 32'(sh[15:8]), RESP_OKAY);
        chk("wiper", 32'(wiper_q), {12'(sh[15:8]), 12'(sh[7:0])});
        end_sim();
    end
endmodule
bind dac_latch_powerdown_control dac_ctl_checker #(.NCH(NCH), .DAC_W(DAC_W),
    .ENTRY_CNT(ENTRY_CNT), .EXIT_CNT(EXIT_CNT)) u_chk (.aclk, .aresetn, .transfer_hold_pin,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .wiper_q, .out_ctl_q);
`default_nettype wire
